// >>> bmw_pkg.sv
// Constants for the bridge memory window register bank
`default_nettype none
package bmw_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_NONPREF_BASE  = 8'h20;
    localparam logic [7:0] IDX_NONPREF_LIMIT = 8'h22;
    localparam logic [7:0] IDX_PREF_BASE     = 8'h24;
    localparam logic [7:0] IDX_PREF_LIMIT    = 8'h26;
    localparam logic [7:0] IDX_PREF_BASE_HI  = 8'h28;
    localparam logic [7:0] IDX_PREF_LIMIT_HI = 8'h2c;
    localparam logic [7:0] IDX_WIDTH_LOCK    = 8'h40;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W   = 12;
    localparam int IDX_LSB  = 2;
    localparam int IDX_MSB  = 9;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int WIN_LSB  = 4;
    localparam int WIN_MSB  = 15;
    localparam int WIN_W    = 12;
    localparam int CAP_BIT  = 0;
    localparam int LOW_W    = 20;
    localparam int LOCK_BIT = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [11:0] RST_NONPREF_BASE  = 12'hfff;
    localparam logic [11:0] RST_NONPREF_LIMIT = 12'h000;
    localparam logic        RST_WIDE_CAP      = 1'b1;
    localparam logic [11:0] RST_PREF_BASE     = 12'hfff;
    localparam logic [11:0] RST_PREF_LIMIT    = 12'h000;
    localparam logic [31:0] RST_PREF_BASE_HI  = 32'hffffffff;
    localparam logic [31:0] RST_PREF_LIMIT_HI = 32'h00000000;

    // Low address bits implied by a base or limit field
    localparam logic [19:0] LIMIT_LOW_ONES = 20'hfffff;
    localparam logic [19:0] BASE_LOW_ZERO  = 20'h00000;

    // ------------------------------------------------------------
    // AXI responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : bmw_pkg
`default_nettype wire

// >>> bmw_regs.sv
// Bridge memory window registers with AXI4-Lite access and window decode
`timescale 1ns/1ps
`default_nettype none

// Function
// R01: Non-prefetchable limit bits 15:4 hold A[31:20]; low bits ones; reset 0.
// R02: Non-prefetchable base bits 15:4 hold A[31:20], 1MB aligned; reset 0xfff.
// R03: Prefetch base bit 0 selects 32/64-bit width; reset 1; lockable.
// R04: Prefetch base bits 15:4 hold A[31:20], 1MB aligned, reset 0xfff.
// R05: Prefetch limit bits 15:4 hold A[31:20]; low bits ones; reset 0.
// R06: Prefetch limit bit 0 is read-only mirror of width bit.
// R07: Prefetch base high register gives A[63:32]; read-write; resets ones.
// R08: Prefetch limit high register gives A[63:32]; read-write; resets zero.
// R09: With width bit 0, both high registers ignore writes, read zero.
// R10: Reserved low bits of window registers are read-only zero.
// R11: Forward request inside either window inclusive; 64-bit compare only wide.
module bmw_regs (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              arst_n_i,
    // AXI4-Lite write address
    input  wire logic [11:0]       s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    // AXI4-Lite read address
    input  wire logic [11:0]       s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    // AXI4-Lite read data
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    // Memory request decode
    input  wire logic [63:0]       req_addr_i,
    input  wire logic              req_valid_i,
    output logic                   fwd_valid_o,
    output logic                   fwd_nonpref_o,
    output logic                   fwd_pref_o,
    output logic                   fwd_hit_o,
    // Window state
    output logic                   wide_addressing_o
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [11:0] nonpref_base_reg;
    logic [11:0] nonpref_limit_reg;
    logic        wide_cap_reg;
    logic [11:0] pref_base_reg;
    logic [11:0] pref_limit_reg;
    logic [31:0] pref_base_hi_reg;
    logic [31:0] pref_limit_hi_reg;
    logic        width_lock_reg;

    // ------------------------------------------------------------
    // Write channel capture
    // ------------------------------------------------------------
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [7:0]  aw_idx_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        wr_fire;
    logic        wr_mapped;

    // Address and data accepted in either order, one write at a time
    assign s_axi_awready_o = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready_o  = !w_held_reg && !bvalid_reg;
    assign wr_fire         = aw_held_reg && w_held_reg && !bvalid_reg;
    assign s_axi_bvalid_o  = bvalid_reg;
    assign s_axi_bresp_o   = bresp_reg;

    function automatic logic mapped(input logic [7:0] idx);
        mapped = (idx == bmw_pkg::IDX_NONPREF_BASE)
              || (idx == bmw_pkg::IDX_NONPREF_LIMIT)
              || (idx == bmw_pkg::IDX_PREF_BASE)
              || (idx == bmw_pkg::IDX_PREF_LIMIT)
              || (idx == bmw_pkg::IDX_PREF_BASE_HI)
              || (idx == bmw_pkg::IDX_PREF_LIMIT_HI)
              || (idx == bmw_pkg::IDX_WIDTH_LOCK);
    endfunction

    // Byte-lane merge of new data into an old word
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        merge = res;
    endfunction

    assign wr_mapped = mapped(aw_idx_reg);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aw_held_reg <= 1'b0;
            aw_idx_reg  <= 8'h00;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held_reg <= 1'b1;
            aw_idx_reg  <= s_axi_awaddr_i[bmw_pkg::IDX_MSB:bmw_pkg::IDX_LSB];
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata_i;
            w_strb_reg <= s_axi_wstrb_i;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= bmw_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_mapped ? bmw_pkg::RESP_OKAY
                                    : bmw_pkg::RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Register updates
    // ------------------------------------------------------------
    logic [31:0] wr_word;
    logic [31:0] old_word;

    always_comb begin
        case (aw_idx_reg)
            bmw_pkg::IDX_NONPREF_BASE:
                old_word = {16'h0000, nonpref_base_reg, 4'h0};
            bmw_pkg::IDX_NONPREF_LIMIT:
                old_word = {16'h0000, nonpref_limit_reg, 4'h0};
            bmw_pkg::IDX_PREF_BASE:
                old_word = {16'h0000, pref_base_reg, 3'h0, wide_cap_reg};
            bmw_pkg::IDX_PREF_LIMIT:
                old_word = {16'h0000, pref_limit_reg, 4'h0};
            bmw_pkg::IDX_PREF_BASE_HI:  old_word = pref_base_hi_reg;
            bmw_pkg::IDX_PREF_LIMIT_HI: old_word = pref_limit_hi_reg;
            bmw_pkg::IDX_WIDTH_LOCK:    old_word = {31'h0, width_lock_reg};
            default:                    old_word = 32'h00000000;
        endcase
        wr_word = merge(old_word, w_data_reg, w_strb_reg);
    end

    // R02: non-prefetchable base field
    // R01: non-prefetchable limit field
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            nonpref_base_reg  <= bmw_pkg::RST_NONPREF_BASE;
            nonpref_limit_reg <= bmw_pkg::RST_NONPREF_LIMIT;
        end else if (wr_fire) begin
            if (aw_idx_reg == bmw_pkg::IDX_NONPREF_BASE) begin
                nonpref_base_reg <=
                    wr_word[bmw_pkg::WIN_MSB:bmw_pkg::WIN_LSB];
            end
            if (aw_idx_reg == bmw_pkg::IDX_NONPREF_LIMIT) begin
                nonpref_limit_reg <=
                    wr_word[bmw_pkg::WIN_MSB:bmw_pkg::WIN_LSB];
            end
        end
    end

    // R03: width bit, frozen once the lock is set
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wide_cap_reg   <= bmw_pkg::RST_WIDE_CAP;
            width_lock_reg <= 1'b0;
        end else if (wr_fire) begin
            if (aw_idx_reg == bmw_pkg::IDX_PREF_BASE && !width_lock_reg) begin
                wide_cap_reg <= wr_word[bmw_pkg::CAP_BIT];
            end
            // Lock is sticky until reset so a driver cannot undo it
            if (aw_idx_reg == bmw_pkg::IDX_WIDTH_LOCK
                && wr_word[bmw_pkg::LOCK_BIT]) begin
                width_lock_reg <= 1'b1;
            end
        end
    end

    // R04: prefetchable base field
    // R05: prefetchable limit field
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pref_base_reg  <= bmw_pkg::RST_PREF_BASE;
            pref_limit_reg <= bmw_pkg::RST_PREF_LIMIT;
        end else if (wr_fire) begin
            if (aw_idx_reg == bmw_pkg::IDX_PREF_BASE) begin
                pref_base_reg <= wr_word[bmw_pkg::WIN_MSB:bmw_pkg::WIN_LSB];
            end
            if (aw_idx_reg == bmw_pkg::IDX_PREF_LIMIT) begin
                pref_limit_reg <= wr_word[bmw_pkg::WIN_MSB:bmw_pkg::WIN_LSB];
            end
        end
    end

    // R07: base high word
    // R08: limit high word
    // R09: high words frozen in narrow mode
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pref_base_hi_reg  <= bmw_pkg::RST_PREF_BASE_HI;
            pref_limit_hi_reg <= bmw_pkg::RST_PREF_LIMIT_HI;
        end else if (wr_fire && wide_cap_reg) begin
            if (aw_idx_reg == bmw_pkg::IDX_PREF_BASE_HI) begin
                pref_base_hi_reg <= wr_word;
            end
            if (aw_idx_reg == bmw_pkg::IDX_PREF_LIMIT_HI) begin
                pref_limit_hi_reg <= wr_word;
            end
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    logic [31:0] base_hi_vis;
    logic [31:0] limit_hi_vis;
    logic [31:0] rd_word;
    logic [7:0]  ar_idx;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    // R09: high words read zero in narrow mode
    assign base_hi_vis  = wide_cap_reg ? pref_base_hi_reg  : 32'h00000000;
    assign limit_hi_vis = wide_cap_reg ? pref_limit_hi_reg : 32'h00000000;
    assign ar_idx       = s_axi_araddr_i[bmw_pkg::IDX_MSB:bmw_pkg::IDX_LSB];

    // R10: reserved bits return zero
    // R06: limit bit 0 mirrors width bit
    always_comb begin
        case (ar_idx)
            bmw_pkg::IDX_NONPREF_BASE:
                rd_word = {16'h0000, nonpref_base_reg, 4'h0};
            bmw_pkg::IDX_NONPREF_LIMIT:
                rd_word = {16'h0000, nonpref_limit_reg, 4'h0};
            bmw_pkg::IDX_PREF_BASE:
                rd_word = {16'h0000, pref_base_reg, 3'h0, wide_cap_reg};
            bmw_pkg::IDX_PREF_LIMIT:
                rd_word = {16'h0000, pref_limit_reg, 3'h0, wide_cap_reg};
            bmw_pkg::IDX_PREF_BASE_HI:  rd_word = base_hi_vis;
            bmw_pkg::IDX_PREF_LIMIT_HI: rd_word = limit_hi_vis;
            bmw_pkg::IDX_WIDTH_LOCK:    rd_word = {31'h0, width_lock_reg};
            default:                    rd_word = 32'h00000000;
        endcase
    end

    assign s_axi_arready_o = !rvalid_reg;
    assign s_axi_rvalid_o  = rvalid_reg;
    assign s_axi_rdata_o   = rdata_reg;
    assign s_axi_rresp_o   = rresp_reg;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h00000000;
            rresp_reg  <= bmw_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_i && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_word;
            rresp_reg  <= mapped(ar_idx) ? bmw_pkg::RESP_OKAY
                                         : bmw_pkg::RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Window decode
    // ------------------------------------------------------------
    logic [31:0] np_lo;
    logic [31:0] np_hi;
    logic [63:0] pf_lo;
    logic [63:0] pf_hi;
    logic        np_in;
    logic        pf_in;

    assign np_lo = {nonpref_base_reg, bmw_pkg::BASE_LOW_ZERO};
    assign np_hi = {nonpref_limit_reg, bmw_pkg::LIMIT_LOW_ONES};
    assign pf_lo = {base_hi_vis, pref_base_reg, bmw_pkg::BASE_LOW_ZERO};
    assign pf_hi = {limit_hi_vis, pref_limit_reg, bmw_pkg::LIMIT_LOW_ONES};

    // R11: inclusive compare; narrow windows only see the low 4GB
    assign np_in = (req_addr_i[63:32] == 32'h00000000)
                && (req_addr_i[31:0] >= np_lo)
                && (req_addr_i[31:0] <= np_hi);
    assign pf_in = (req_addr_i >= pf_lo) && (req_addr_i <= pf_hi);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fwd_valid_o   <= 1'b0;
            fwd_nonpref_o <= 1'b0;
            fwd_pref_o    <= 1'b0;
            fwd_hit_o     <= 1'b0;
        end else begin
            fwd_valid_o   <= req_valid_i;
            fwd_nonpref_o <= req_valid_i && np_in;
            fwd_pref_o    <= req_valid_i && pf_in;
            fwd_hit_o     <= req_valid_i && (np_in || pf_in);
        end
    end

    assign wide_addressing_o = wide_cap_reg;

endmodule // bmw_regs

`default_nettype wire

// >>> bmw_regs_bench.sv
// Self-checking bench for the bridge memory window register bank
`timescale 1ns/1ps
`default_nettype none
module bmw_regs_bench;
    logic        clk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic [11:0] s_axi_awaddr_i = 12'h0, s_axi_araddr_i = 12'h0;
    logic [31:0] s_axi_wdata_i = 32'h0;
    logic [3:0]  s_axi_wstrb_i = 4'h0;
    logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
    logic        s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
    logic        s_axi_rready_i = 1'b0, req_valid_i = 1'b0;
    logic [63:0] req_addr_i = 64'h0;
    logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
    logic        s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
    logic [31:0] s_axi_rdata_o;
    logic        fwd_valid_o, fwd_nonpref_o, fwd_pref_o, fwd_hit_o;
    logic        wide_addressing_o;
    // Model state, starting at the reset values
    logic [11:0] nb = 12'hfff, nl = 12'h000, pb = 12'hfff, pl = 12'h000;
    logic [31:0] bh = 32'hffffffff, lh = 32'h0;
    logic        wd = 1'b1, lk = 1'b0;
    logic [11:0] regs [8] = '{12'h080, 12'h088, 12'h090, 12'h098,
                              12'h0a0, 12'h0b0, 12'h100, 12'h004};
    logic [63:0] pts [10] = '{64'h10000000, 64'h1fffffff, 64'h20000000,
        64'h0fffffff, 64'h140000000, 64'h13fffffff, 64'h24fffffff,
        64'h250000000, 64'h110000000, 64'h4fffffff};
    int          n_errors = 0, checked = 0, cyc = 0, seed = 19, k;

    bmw_regs bmw_regs_inst (
        .clk_i(clk_i), .arst_n_i(arst_n_i),
        .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
        .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
        .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
        .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
        .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
        .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
        .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
        .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
        .s_axi_rready_i(s_axi_rready_i), .req_addr_i(req_addr_i),
        .req_valid_i(req_valid_i), .fwd_valid_o(fwd_valid_o),
        .fwd_nonpref_o(fwd_nonpref_o), .fwd_pref_o(fwd_pref_o),
        .fwd_hit_o(fwd_hit_o), .wide_addressing_o(wide_addressing_o)
    );

    always #2 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_errors = n_errors + 1;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [63:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    function automatic logic mapped(input logic [11:0] a);
        return a inside {12'h080, 12'h088, 12'h090, 12'h098, 12'h0a0,
                         12'h0b0, 12'h100};
    endfunction

    function automatic logic [31:0] mrd(input logic [11:0] a);
        case (a)
            12'h080: return {16'h0, nb, 4'h0};
            12'h088: return {16'h0, nl, 4'h0};
            12'h090: return {16'h0, pb, 3'h0, wd};
            12'h098: return {16'h0, pl, 3'h0, wd};
            12'h0a0: return wd ? bh : 32'h0;
            12'h0b0: return wd ? lh : 32'h0;
            12'h100: return {31'h0, lk};
            default: return 32'h0;
        endcase
    endfunction

    task automatic mwr(input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        logic [31:0] m, v;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        v = (mrd(a) & ~m) | (d & m);
        case (a)
            12'h080: nb = v[15:4];
            12'h088: nl = v[15:4];
            12'h090: begin
                pb = v[15:4];
                if (!lk) wd = v[0];
            end
            12'h098: pl = v[15:4];
            12'h0a0: if (wd) bh = v;
            12'h0b0: if (wd) lh = v;
            12'h100: lk = lk | v[0];
            default: ;
        endcase
    endtask

    function automatic logic [2:0] mdec(input logic [63:0] a);
        logic np, pf;
        np = a[63:32] == 32'h0 && a[31:20] >= nb && a[31:20] <= nl;
        pf = a >= {wd ? bh : 32'h0, pb, 20'h0}
            && a <= {wd ? lh : 32'h0, pl, 20'hfffff};
        return {np, pf, np | pf};
    endfunction

    // ------------------------------------------------------------
    // Drivers; ready is read at the falling edge, where it is settled
    // ------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        logic ha, hw, ta, tw;
        ha = 1'b1;
        hw = 1'b1;
        @(posedge clk_i);
        s_axi_awaddr_i  <= a;
        s_axi_wdata_i   <= d;
        s_axi_wstrb_i   <= s;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i  <= 1'b1;
        s_axi_bready_i  <= 1'b1;
        while (ha || hw) begin
            @(negedge clk_i);
            ta = ha && s_axi_awready_o;
            tw = hw && s_axi_wready_o;
            @(posedge clk_i);
            if (ta) s_axi_awvalid_i <= 1'b0;
            if (tw) s_axi_wvalid_i <= 1'b0;
            ha = ha && !ta;
            hw = hw && !tw;
        end
        do @(negedge clk_i); while (!s_axi_bvalid_o);
        chk("bresp", s_axi_bresp_o, mapped(a) ? 2'h0 : 2'h2);
        @(posedge clk_i);
        s_axi_bready_i <= 1'b0;
        if (mapped(a)) mwr(a, d, s);
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge clk_i);
        s_axi_araddr_i  <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i  <= 1'b1;
        do @(negedge clk_i); while (!s_axi_arready_o);
        @(posedge clk_i);
        s_axi_arvalid_i <= 1'b0;
        do @(negedge clk_i); while (!s_axi_rvalid_o);
        chk("rdata", s_axi_rdata_o, mrd(a));
        chk("rresp", s_axi_rresp_o, mapped(a) ? 2'h0 : 2'h2);
        chk("wide", wide_addressing_o, wd);
        @(posedge clk_i);
        s_axi_rready_i <= 1'b0;
    endtask

    task automatic dec(input logic [63:0] a);
        logic [2:0] e;
        e = mdec(a);
        @(posedge clk_i);
        req_addr_i  <= a;
        req_valid_i <= 1'b1;
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        #1;
        chk("fwd", {fwd_valid_o, fwd_nonpref_o, fwd_pref_o, fwd_hit_o},
            {1'b1, e});
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        arst_n_i <= 1'b1;
        foreach (regs[i]) rd(regs[i]);
        $display("reset value test done");
        foreach (regs[i]) if (i != 6) wr(regs[i], 32'hffffffff, 4'hf);
        foreach (regs[i]) rd(regs[i]);
        repeat (40) begin
            k = $unsigned($random(seed)) % 6;
            wr(regs[k], $random(seed), 4'($random(seed)));
            rd(regs[k]);
        end
        $display("field and strobe test done");
        wr(12'h090, 32'h00004001, 4'h3);
        wr(12'h0a0, 32'h00000001, 4'hf);
        wr(12'h0b0, 32'h00000002, 4'hf);
        wr(12'h080, 32'h00001000, 4'h3);
        wr(12'h088, 32'h00001ff0, 4'h3);
        wr(12'h098, 32'h00004ff0, 4'h3);
        foreach (pts[i]) dec(pts[i]);
        repeat (60) dec({30'h0, 2'($random(seed)), 32'($random(seed))});
        wr(12'h090, 32'h00004000, 4'h3);
        foreach (pts[i]) dec(pts[i]);
        wr(12'h0a0, 32'h5a5a5a5a, 4'hf);
        rd(12'h0a0);
        rd(12'h0b0);
        rd(12'h098);
        repeat (60) dec({30'h0, 2'($random(seed)), 32'($random(seed))});
        wr(12'h090, 32'h00004001, 4'h3);
        rd(12'h0a0);
        $display("window decode test done");
        wr(12'h100, 32'h00000001, 4'h1);
        wr(12'h090, 32'h00000000, 4'h3);
        rd(12'h090);
        rd(12'h100);
        $display("width lock test done");
        print_verdict();
    end
endmodule // bmw_regs_bench
`default_nettype wire

// >>> bmw_regs_checker.sv
// Concurrent assertions for the bridge memory window register bank
`timescale 1ns/1ps
`default_nettype none
module bmw_regs_checker (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        arst_n_i,
    // Register bus
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_wready_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic [11:0] s_axi_araddr_i,
    input wire logic        s_axi_arvalid_i,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic        s_axi_rvalid_o,
    // Window decode
    input wire logic [63:0] req_addr_i,
    input wire logic        req_valid_i,
    input wire logic        fwd_valid_o,
    input wire logic        fwd_nonpref_o,
    input wire logic        fwd_pref_o,
    input wire logic        fwd_hit_o,
    input wire logic        wide_addressing_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    read_answer_a:
        assert property (s_axi_arvalid_i && !s_axi_rvalid_o |=> s_axi_rvalid_o)
        else $error("read not answered in one cycle");
    write_block_a:
        assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write taken while response pending");
    mirror_bit_a:
        assert property ($rose(s_axi_rvalid_o)
            && $past(s_axi_araddr_i) == 12'h098
            |-> s_axi_rdata_o[0] == $past(wide_addressing_o))
        else $error("limit width bit differs from base width bit");
    reserved_zero_a:
        assert property ($rose(s_axi_rvalid_o) && $past(s_axi_araddr_i) inside
            {12'h088, 12'h090, 12'h098}
            |-> s_axi_rdata_o[31:16] == 16'h0 && s_axi_rdata_o[3:1] == 3'h0)
        else $error("reserved bits read nonzero");
    narrow_zero_a:
        assert property ($rose(s_axi_rvalid_o) && !$past(wide_addressing_o)
            && $past(s_axi_araddr_i) inside {12'h0a0, 12'h0b0}
            |-> s_axi_rdata_o == 32'h0) else $error("high register not zero");
    nonpref_low_a:
        assert property (req_valid_i && req_addr_i[63:32] != 32'h0
            |=> !fwd_nonpref_o) else $error("wide address hit narrow window");
    narrow_pref_a:
        assert property (req_valid_i && !wide_addressing_o
            && req_addr_i[63:32] != 32'h0 |=> !fwd_pref_o)
        else $error("wide address hit prefetch window in narrow mode");
    hit_merge_a:
        assert property (fwd_hit_o
            == (fwd_valid_o && (fwd_nonpref_o || fwd_pref_o)))
        else $error("hit flag disagrees with window flags");
endmodule // bmw_regs_checker

bind bmw_regs bmw_regs_checker bmw_regs_checker_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i),
    .s_axi_awready_o(s_axi_awready_o), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .req_addr_i(req_addr_i),
    .req_valid_i(req_valid_i), .fwd_valid_o(fwd_valid_o),
    .fwd_nonpref_o(fwd_nonpref_o), .fwd_pref_o(fwd_pref_o),
    .fwd_hit_o(fwd_hit_o), .wide_addressing_o(wide_addressing_o)
);
`default_nettype wire
